// ==== include/dcr_map.svh ====
// Register map, field positions, reset values and bus constants
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DCR_OFS_ADDR        8'h00
`define DCR_OFS_SRST        8'h01
`define DCR_OFS_PIN0        8'h02

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DCR_ADDR_MSB        7
`define DCR_ADDR_LSB        1
`define DCR_SRST_BIT        0
`define DCR_SRC_MSB         7
`define DCR_SRC_LSB         4
`define DCR_PULL_MSB        3
`define DCR_PULL_LSB        2
`define DCR_INBUF_BIT       1
`define DCR_OE_BIT          0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define DCR_PIN0_RST        8'h05
`define DCR_SRST_RST        1'h0
`define DCR_SRC_GPOUT       4'h0
`define DCR_SRC_SD0         4'h1
`define DCR_PULL_NONE       2'h0
`define DCR_PULL_DOWN       2'h1
`define DCR_PULL_UP         2'h2
`define DCR_BITS_PER_BYTE   4'h8
`define DCR_SYNC_W          5

`endif

// ==== include/dcr_pkg.sv ====
// Types shared by the configuration register bank
package dcr_pkg;

   typedef enum logic [2:0] {
      DCR_IDLE,
      DCR_RX,
      DCR_ACK,
      DCR_TX,
      DCR_RACK,
      DCR_TXL,
      DCR_WAIT
   } dcr_state_t;

endpackage

// ==== verilog/dcr_sync.sv ====
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps

module dcr_sync #(
   parameter int        W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,   // System clock
   input  wire logic         srst,  // Synchronous reset
   input  wire logic [W-1:0] d,     // Asynchronous inputs
   output logic      [W-1:0] q      // Synchronised outputs
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
      if (srst) begin
         meta_next = INIT;
         q_next    = INIT;
      end
   end

   always_ff @(posedge clk) begin
      meta_reg <= meta_next;
      q        <= q_next;
   end

endmodule

// ==== verilog/dcr_regs.sv ====
// Configuration register bank with management bus slave and pin 0 control
//
// Contract
// (R1) Bits 7:1 of register zero hold the writable 7-bit bus target address.
// (R2) The host keeps bit 0 of register zero at zero when writing it.
// (R3) Writing one to bit 0 of register one soft-resets the device state.
// (R4) A soft reset leaves register zero and the address untouched.
// (R5) Bits 7:4 of register two route pin 0 from the output value or detect.
// (R6) Bits 3:2 of register two pick no pull, pulldown or pullup.
// (R7) Bit 1 of register two enables the pin 0 input buffer, reset off.
// (R8) The host clears output enable before using pin 0 as an input.
// (R9) Output enable resets to one; host keeps input buffer off for output.
// (R10) In detect mode pin 0 is low with no signal on input 0, else high.
// (R11) The device answers bus transactions only while chip select is high.
// (R12) The soft reset bit clears itself once the reset has been applied.
`timescale 1ns/1ps
`include "dcr_map.svh"

module dcr_regs
   import dcr_pkg::*;
#(
   parameter logic [6:0] DEF_ADDR = 7'h2a  // Arbitrary default address
) (
   input  wire logic       clk,              // 25 MHz system clock
   input  wire logic       srst,             // Synchronous reset, high
   input  wire logic       scl_in,           // Bus clock pin
   input  wire logic       sda_in,           // Bus data pin level
   output logic            sda_out,          // Bus data drive value
   output logic            sda_oe,           // Bus data pulls low
   input  wire logic       bus_chip_select,  // Device select, high
   input  wire logic       sig_detect0,      // Signal present on input 0
   input  wire logic       gp_out_value,     // Output register value
   input  wire logic       pin0_in,          // Pin 0 level
   output logic            pin0_out,         // Pin 0 drive value
   output logic            pin0_oe,          // Pin 0 driver enable
   output logic            pin0_pull_up,     // Pin 0 pullup on
   output logic            pin0_pull_down,   // Pin 0 pulldown on
   output logic            pin0_in_value,    // Buffered pin 0 level
   output logic            soft_reset_pulse, // Soft reset to the device
   output logic [6:0]      bus_target_addr   // Current bus address
);

   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   logic                   scl_s;
   logic                   sda_s;
   logic                   cs_s;
   logic                   sd0_s;
   logic                   pin0_s;

   // Idle bus lines start high so reset release makes no false edge
   dcr_sync #(
      .W    (`DCR_SYNC_W),
      .INIT (5'h03)
   ) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({pin0_in, sig_detect0, bus_chip_select, sda_in, scl_in}),
      .q    ({pin0_s, sd0_s, cs_s, sda_s, scl_s})
   );

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   dcr_state_t state_reg,   state_next;
   logic [3:0] bitcnt_reg,  bitcnt_next;
   logic [7:0] shift_reg,   shift_next;
   logic [7:0] ptr_reg,     ptr_next;
   logic [1:0] phase_reg,   phase_next;
   logic       rw_reg,      rw_next;
   logic       scl_d_reg,   scl_d_next;
   logic       sda_d_reg,   sda_d_next;
   logic       sda_oe_next;
   logic [6:0] addr_reg,    addr_next;
   logic       srst_bit_reg, srst_bit_next;
   logic [7:0] cfg_reg,     cfg_next;
   logic       pin0_out_next;
   logic       pull_up_next;
   logic       pull_down_next;
   logic       in_value_next;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   logic [7:0] rd_data;
   logic [7:0] rx_byte;
   logic [3:0] src;
   logic [1:0] pull;

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign rx_byte  = shift_reg;
   assign src      = cfg_reg[`DCR_SRC_MSB:`DCR_SRC_LSB];
   assign pull     = cfg_reg[`DCR_PULL_MSB:`DCR_PULL_LSB];

   // -------------------------------------------------------------------
   // Register read mux
   // -------------------------------------------------------------------
   always_comb begin
      case (ptr_reg)
         `DCR_OFS_ADDR: rd_data = {addr_reg, 1'b0};        // see (R1)
         `DCR_OFS_SRST: rd_data = {7'h00, srst_bit_reg};
         `DCR_OFS_PIN0: rd_data = cfg_reg;
         default:       rd_data = 8'h00;
      endcase
   end

   // -------------------------------------------------------------------
   // Bus slave and registers
   // -------------------------------------------------------------------
   always_comb begin
      state_next    = state_reg;
      bitcnt_next   = bitcnt_reg;
      shift_next    = shift_reg;
      ptr_next      = ptr_reg;
      phase_next    = phase_reg;
      rw_next       = rw_reg;
      scl_d_next    = scl_s;
      sda_d_next    = sda_s;
      sda_oe_next   = sda_oe;
      addr_next     = addr_reg;
      srst_bit_next = srst_bit_reg;
      cfg_next      = cfg_reg;
      // Soft reset restores config but never the address
      if (srst_bit_reg) begin
         cfg_next      = `DCR_PIN0_RST;                    // see (R3) (R4)
         srst_bit_next = 1'b0;                             // see (R12)
      end
      case (state_reg)
         DCR_RX: begin
            if (scl_rise) begin
               shift_next  = {shift_reg[6:0], sda_s};
               bitcnt_next = 4'(bitcnt_reg + 4'h1);
            end else if (scl_fall && bitcnt_reg == `DCR_BITS_PER_BYTE) begin
               bitcnt_next = 4'h0;
               state_next  = DCR_ACK;
               sda_oe_next = 1'b1;
               case (phase_reg)
                  2'h0: begin
                     if (rx_byte[7:1] == addr_reg) begin
                        rw_next    = rx_byte[0];
                        phase_next = 2'h1;
                     end else begin
                        // Not ours: stay off the bus until the next start
                        state_next  = DCR_WAIT;
                        sda_oe_next = 1'b0;
                     end
                  end
                  2'h1: begin
                     ptr_next   = rx_byte;
                     phase_next = 2'h2;
                  end
                  default: begin
                     case (ptr_reg)
                        `DCR_OFS_ADDR:                   // see (R1) (R2)
                           // Low bit is reserved, kept zero by the host
                           addr_next = rx_byte[`DCR_ADDR_MSB:`DCR_ADDR_LSB];
                        `DCR_OFS_SRST:
                           if (rx_byte[`DCR_SRST_BIT])
                              srst_bit_next = 1'b1;        // see (R3)
                        `DCR_OFS_PIN0:
                           cfg_next = rx_byte;             // see (R5) (R6) (R7)
                        default: ;
                     endcase
                     ptr_next = 8'(ptr_reg + 8'h01);
                  end
               endcase
            end
         end
         DCR_ACK: begin
            if (scl_fall) begin
               if (rw_reg && phase_reg == 2'h1) begin
                  shift_next  = rd_data;
                  sda_oe_next = ~rd_data[7];
                  bitcnt_next = 4'h0;
                  state_next  = DCR_TX;
               end else begin
                  sda_oe_next = 1'b0;
                  state_next  = DCR_RX;
               end
            end
         end
         DCR_TXL: begin
            if (scl_fall) begin
               shift_next  = rd_data;
               sda_oe_next = ~rd_data[7];
               bitcnt_next = 4'h0;
               state_next  = DCR_TX;
            end
         end
         DCR_TX: begin
            if (scl_fall) begin
               if (bitcnt_reg == 4'h7) begin
                  sda_oe_next = 1'b0;
                  state_next  = DCR_RACK;
               end else begin
                  shift_next  = {shift_reg[6:0], 1'b0};
                  sda_oe_next = ~shift_reg[6];
                  bitcnt_next = 4'(bitcnt_reg + 4'h1);
               end
            end
         end
         DCR_RACK: begin
            if (scl_rise) begin
               if (sda_s) begin
                  state_next = DCR_WAIT;
               end else begin
                  ptr_next   = 8'(ptr_reg + 8'h01);
                  state_next = DCR_TXL;
               end
            end
         end
         DCR_IDLE, DCR_WAIT: ;
         default: state_next = DCR_IDLE;
      endcase
      if (stop_ev) begin
         state_next  = DCR_IDLE;
         sda_oe_next = 1'b0;
      end
      if (start_ev) begin
         state_next  = DCR_RX;
         bitcnt_next = 4'h0;
         phase_next  = 2'h0;
         sda_oe_next = 1'b0;
      end
      // Deselected device drops any transfer and releases the line
      if (!cs_s) begin
         state_next  = DCR_IDLE;                           // see (R11)
         sda_oe_next = 1'b0;                               // see (R11)
      end
      if (srst) begin
         state_next    = DCR_IDLE;
         bitcnt_next   = 4'h0;
         shift_next    = 8'h00;
         ptr_next      = 8'h00;
         phase_next    = 2'h0;
         rw_next       = 1'b0;
         scl_d_next    = 1'b1;
         sda_d_next    = 1'b1;
         sda_oe_next   = 1'b0;
         addr_next     = DEF_ADDR;
         srst_bit_next = `DCR_SRST_RST;
         cfg_next      = `DCR_PIN0_RST;                    // see (R7) (R9)
      end
   end

   always_ff @(posedge clk) begin
      state_reg    <= state_next;
      bitcnt_reg   <= bitcnt_next;
      shift_reg    <= shift_next;
      ptr_reg      <= ptr_next;
      phase_reg    <= phase_next;
      rw_reg       <= rw_next;
      scl_d_reg    <= scl_d_next;
      sda_d_reg    <= sda_d_next;
      sda_oe       <= sda_oe_next;
      addr_reg     <= addr_next;
      srst_bit_reg <= srst_bit_next;
      cfg_reg      <= cfg_next;
   end

   // -------------------------------------------------------------------
   // Pin 0 outputs
   // -------------------------------------------------------------------
   always_comb begin
      case (src)
         `DCR_SRC_GPOUT: pin0_out_next = gp_out_value;     // see (R5)
         `DCR_SRC_SD0:   pin0_out_next = sd0_s;            // see (R5) (R10)
         default:        pin0_out_next = 1'b0;
      endcase
      pull_up_next   = (pull == `DCR_PULL_UP);             // see (R6)
      pull_down_next = (pull == `DCR_PULL_DOWN);           // see (R6)
      // Gated so a floating pin never reaches the core
      in_value_next  = cfg_reg[`DCR_INBUF_BIT] & pin0_s;   // see (R7)
      if (srst) begin
         pin0_out_next  = 1'b0;
         pull_up_next   = 1'b0;
         pull_down_next = 1'b1;
         in_value_next  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      pin0_out       <= pin0_out_next;
      pin0_oe        <= srst | cfg_reg[`DCR_OE_BIT];       // see (R9) (R8)
      pin0_pull_up   <= pull_up_next;
      pin0_pull_down <= pull_down_next;
      pin0_in_value  <= in_value_next;
      sda_out        <= 1'b0;
   end

   assign soft_reset_pulse = srst_bit_reg;
   assign bus_target_addr  = addr_reg;

endmodule

// ==== testbench/dcr_regs_assertions.sv ====
// Port-level checker for the configuration register bank
`timescale 1ns/1ps

module dcr_regs_assertions #(
   parameter logic [6:0] DEF_ADDR = 7'h2a  // Address after reset
) (
   input  wire logic       clk,              // System clock
   input  wire logic       srst,             // Synchronous reset
   input  wire logic       sda_oe,           // Bus data pulls low
   input  wire logic       bus_chip_select,  // Device select
   input  wire logic       pin0_in,          // Pin 0 level
   input  wire logic       pin0_oe,          // Pin 0 driver enable
   input  wire logic       pin0_pull_up,     // Pullup on
   input  wire logic       pin0_pull_down,   // Pulldown on
   input  wire logic       pin0_in_value,    // Buffered pin level
   input  wire logic       soft_reset_pulse, // Soft reset strobe
   input  wire logic [6:0] bus_target_addr   // Current address
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   property p_reset_vals;
      disable iff (1'b0)
      srst |=> pin0_oe && pin0_pull_down && !pin0_pull_up && !pin0_in_value
         && !soft_reset_pulse && bus_target_addr == DEF_ADDR;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("pin or address wrong after reset");

   property p_pull_excl;
      !(pin0_pull_up && pin0_pull_down);
   endproperty
   a_pull_excl: assert property (p_pull_excl)
      else $error("pullup and pulldown both on");

   property p_pulse_one;
      soft_reset_pulse |=> !soft_reset_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("soft reset strobe longer than one cycle");

   property p_srst_addr;
      soft_reset_pulse |-> ##1 $stable(bus_target_addr);
   endproperty
   a_srst_addr: assert property (p_srst_addr)
      else $error("address disturbed by soft reset");

   // Config is restored one cycle after the strobe, pin flops follow one cycle later
   property p_srst_pin;
      soft_reset_pulse |-> ##2 (pin0_oe && pin0_pull_down && !pin0_pull_up
         && !pin0_in_value);
   endproperty
   a_srst_pin: assert property (p_srst_pin)
      else $error("pin setup not restored by soft reset");

   property p_cs_idle;
      !bus_chip_select [*8] |-> !sda_oe;
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("bus driven while not selected");

   property p_addr_hold;
      !bus_chip_select [*8] |=> $stable(bus_target_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("address changed while not selected");

   property p_inval;
      $rose(pin0_in_value) |-> $past(pin0_in, 3);
   endproperty
   a_inval: assert property (p_inval)
      else $error("buffered level rose without pin high");
endmodule

bind dcr_regs dcr_regs_assertions #(.DEF_ADDR(DEF_ADDR)) u_chk (
   .clk(clk), .srst(srst), .sda_oe(sda_oe),
   .bus_chip_select(bus_chip_select), .pin0_in(pin0_in),
   .pin0_oe(pin0_oe), .pin0_pull_up(pin0_pull_up),
   .pin0_pull_down(pin0_pull_down), .pin0_in_value(pin0_in_value),
   .soft_reset_pulse(soft_reset_pulse), .bus_target_addr(bus_target_addr)
);

// ==== testbench/dcr_host_model.sv ====
// Bus master model that writes and reads the register bank
`timescale 1ns/1ps

module dcr_host_model (
   input  wire logic       clk,      // System clock
   input  wire logic       sda,      // Resolved data wire
   output logic            scl,      // Bus clock, idles high
   output logic            sda_low,  // Host pulls data low
   output logic            rd_valid, // Read byte ready, one cycle
   output logic [7:0]      rd_data,  // Read byte
   output logic            acked     // Every byte acknowledged
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rd_valid = 1'b0;
      rd_data = 8'h00;
      acked = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves mid-low so the device never sees a false start or stop
   task automatic bit_io(input logic b, output logic got);
      tick(4);
      sda_low <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(7);
      got = sda;
      tick(1);
      scl <= 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] b, input logic ab,
                          output logic [7:0] got);
      logic g;
      for (int i = 7; i >= 0; i--) bit_io(b[i], got[i]);
      bit_io(ab, g);
      acked = acked & ~g;
   endtask

   task automatic start;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_low <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask

   task automatic stop;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(8);
      sda_low <= 1'b0;
      tick(8);
   endtask

   task automatic write_reg(input logic [6:0] a, input logic [7:0] o, d);
      logic [7:0] g;
      acked = 1'b1;
      start();
      byte_io({a, 1'b0}, 1'b1, g);
      byte_io(o, 1'b1, g);
      byte_io(d, 1'b1, g);
      stop();
   endtask

   task automatic read_reg(input logic [6:0] a, input logic [7:0] o);
      logic [7:0] g;
      logic       ok;
      acked = 1'b1;
      start();
      byte_io({a, 1'b0}, 1'b1, g);
      byte_io(o, 1'b1, g);
      start();
      byte_io({a, 1'b1}, 1'b1, g);
      ok = acked;
      byte_io(8'hff, 1'b1, g); // Master NACK ends the read
      acked = ok;
      rd_data <= g;
      rd_valid <= 1'b1;
      tick(1);
      rd_valid <= 1'b0;
      stop();
   endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps

module tb;
   import dcr_pkg::*;
   localparam logic [6:0] ADDR0 = 7'h2a; // Arbitrary start address
   localparam logic [6:0] NADDR = 7'h15;
   logic       clk, srst, scl, host_low, bus_chip_select, sig_detect0;
   logic       gp_out_value, pin0_in, sda_out, sda_oe, pin0_out, pin0_oe;
   logic       pin0_pull_up, pin0_pull_down, pin0_in_value;
   logic       soft_reset_pulse, rd_valid, acked;
   logic [7:0] rd_data, cfg;
   logic [6:0] bus_target_addr;
   wire        sda;
   int         fail_count, total_checks, pulses, seed;
   logic [7:0] exp_q[$];

   assign sda = !(host_low || (sda_oe && !sda_out)); // Pull-up wire
   always #20 clk = ~clk;

   dcr_regs #(.DEF_ADDR(ADDR0)) u_dcr_regs (
      .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .bus_chip_select(bus_chip_select),
      .sig_detect0(sig_detect0), .gp_out_value(gp_out_value),
      .pin0_in(pin0_in), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
      .pin0_pull_up(pin0_pull_up), .pin0_pull_down(pin0_pull_down),
      .pin0_in_value(pin0_in_value), .soft_reset_pulse(soft_reset_pulse),
      .bus_target_addr(bus_target_addr)
   );
   dcr_host_model u_dcr_host_model (
      .clk(clk), .sda(sda), .scl(scl), .sda_low(host_low),
      .rd_valid(rd_valid), .rd_data(rd_data), .acked(acked)
   );

   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   always @(posedge clk) if (soft_reset_pulse === 1'b1) pulses <= pulses + 1;
   always @(posedge clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(rd_data, 8'hxx);
         else chk(rd_data, exp_q.pop_front());
      end
   end

   task automatic rd(input logic [6:0] a, input logic [7:0] o, e);
      exp_q.push_back(e);
      u_dcr_host_model.read_reg(a, o);
      repeat (2) @(posedge clk);
   endtask

   task automatic pins(input logic [7:0] c);
      logic [7:0] e;
      repeat (10) @(posedge clk);
      e = 8'h00;
      e[4] = (c[7:4] == 4'h1) ? sig_detect0 : 1'b0;
      if (c[7:4] == 4'h0) e[4] = gp_out_value;
      e[3] = c[0];
      e[2] = c[3:2] == 2'h2;
      e[1] = c[3:2] == 2'h1;
      e[0] = c[1] & pin0_in;
      chk({3'h0, pin0_out, pin0_oe, pin0_pull_up, pin0_pull_down,
           pin0_in_value}, e);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      bus_chip_select = 1'b1;
      sig_detect0 = 1'b0;
      gp_out_value = 1'b0;
      pin0_in = 1'b0;
      fail_count = 0;
      total_checks = 0;
      pulses = 0;
      seed = $urandom(16979);
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      repeat (4) @(posedge clk);
      pins(8'h05);
      rd(ADDR0, 8'h00, {ADDR0, 1'b0});
      rd(ADDR0, 8'h01, 8'h00);
      rd(ADDR0, 8'h02, 8'h05);
      rd(ADDR0, 8'h05, 8'h00);
      // Source codes 0 to 2 and every pull code, with random pin levels
      for (int i = 0; i < 12; i++) begin
         cfg = 8'($urandom);
         cfg[7:4] = 4'(i % 3);
         cfg[3:2] = 2'(i % 4);
         if (cfg[1]) cfg[0] = 1'b0;
         gp_out_value <= 1'($urandom);
         sig_detect0 <= i[1];
         pin0_in <= 1'($urandom);
         u_dcr_host_model.write_reg(ADDR0, 8'h02, cfg);
         chk({7'h00, acked}, 8'h01);
         pins(cfg);
         rd(ADDR0, 8'h02, cfg);
      end
      u_dcr_host_model.write_reg(ADDR0, 8'h00, {NADDR, 1'b0});
      chk({1'b0, bus_target_addr}, {1'b0, NADDR});
      rd(NADDR, 8'h00, {NADDR, 1'b0});
      for (int k = 1; k <= 2; k++) begin
         u_dcr_host_model.write_reg(NADDR, 8'h01, 8'h01);
         pins(8'h05);
         chk(8'(pulses), 8'(k));
         rd(NADDR, 8'h01, 8'h00);
         rd(NADDR, 8'h02, 8'h05);
         chk({1'b0, bus_target_addr}, {1'b0, NADDR});
      end
      bus_chip_select <= 1'b0;
      repeat (8) @(posedge clk);
      u_dcr_host_model.write_reg(NADDR, 8'h02, 8'hf0);
      chk({7'h00, acked}, 8'h00);
      bus_chip_select <= 1'b1;
      repeat (8) @(posedge clk);
      rd(NADDR, 8'h02, 8'h05);
      chk(8'(exp_q.size()), 8'h00);
      end_of_test();
   end
endmodule
